// [binary_delay_timer.sv]
`timescale 1ns/1ps

// Behaviour
// R1 - Trigger starts time base, clears all outputs.
// R2 - Triggers ignored while running until reset.
// R3 - Reset blocks tick, sets outputs high.
// R4 - Tick clocks eight-stage counter, stages visible.
// R5 - Combined output low if any selected low.
// R6 - Monostable delay equals weighted sum of stages.
// R7 - Astable runs continuously until external reset.
// R8 - External tick may replace internal time base.
// R9 - Top stage falls after 256 periods.
// R10 - All eight selected: high only at end.
// R11 - External tick counts on falling edge.
// R12 - Reset wins over simultaneous trigger.
// R13 - Selection held fixed during a count; the code accepts select writes at any time, running or not.
module binary_delay_timer #(
   parameter logic [15:0] TB_PERIOD = 16'(timer_pkg::TB_PERIOD_CYCLES)
) (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst,
   // Wishbone slave.
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Control pins.
   input wire logic i_trigger,
   input wire logic i_reset,
   input wire logic i_ext_tick,
   // Open-collector counter pins.
   input wire logic [7:0] i_count_pin,
   output logic [7:0] o_count_pin,
   output logic [7:0] o_count_pin_oe_n,
   // Observation outputs.
   output logic o_combined,
   output logic o_count_msb_output,
   output logic o_count_lsb_output,
   output logic o_count_stage_five_output,
   output logic o_time_base_tick,
   output logic o_running
);

   ////////////////////////////////////////////////////////////////////////////

   typedef struct packed {
      logic [7:0] count;
      logic running;
      logic combined;
      logic tick_out;
      logic trig_prev;
      logic ext_prev;
      logic [7:0] select;
      logic ext_clock;
      logic mono;
      logic [15:0] period;
      logic ack;
      logic [31:0] rdata;
   } timer_state_t;

   timer_state_t state_reg;
   timer_state_t state_next;
   logic int_tick;
   logic tick;
   logic trig_edge;
   logic ext_fall;
   logic wb_req;
   logic wb_write;
   logic [5:0] word_idx;
   logic sw_trigger;
   logic sw_stop;
   logic feedback_stop;
   logic stop;

   ////////////////////////////////////////////////////////////////////////////

   // Internal time base runs only while counting on the internal source.
   tick_divider u_time_base (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_enable(state_reg.running & ~state_reg.ext_clock),
      .i_period(state_reg.period),
      .o_tick(int_tick)
   );

   ////////////////////////////////////////////////////////////////////////////

   // Pin edges, bus decode and the start and stop sources.
   always_comb begin
      trig_edge = i_trigger & ~state_reg.trig_prev;
      ext_fall = state_reg.ext_prev & ~i_ext_tick; // R11
      tick = state_reg.running & (state_reg.ext_clock ? ext_fall : int_tick); // R3 R8
      wb_req = i_wb_cyc & i_wb_stb;
      wb_write = wb_req & i_wb_we & state_reg.ack;
      word_idx = i_wb_adr[7:2];
      sw_trigger = wb_write & (word_idx == timer_pkg::IDX_CTRL) & i_wb_sel[0]
         & i_wb_dat[timer_pkg::CTRL_TRIGGER_BIT];
      sw_stop = wb_write & (word_idx == timer_pkg::IDX_CTRL) & i_wb_sel[0]
         & i_wb_dat[timer_pkg::CTRL_STOP_BIT];
      // Monostable: the combined output going high feeds the reset.
      feedback_stop = state_reg.mono & state_reg.running & state_reg.combined; // R6
      // Without feedback only an outside reset or a bus stop ends the run.
      stop = i_reset | sw_stop | feedback_stop; // R7
   end

   // Next-state logic for the counter, the registers and the bus answer.
   always_comb begin
      state_next = state_reg;
      state_next.trig_prev = i_trigger;
      state_next.ext_prev = i_ext_tick;
      state_next.tick_out = tick;

      // Stop takes priority over any trigger in the same cycle.
      if (stop) begin // R12
         state_next.count = timer_pkg::COUNT_STOPPED; // R3
         state_next.running = 1'b0;
      end else if ((trig_edge | sw_trigger) & ~state_reg.running) begin // R2
         state_next.count = timer_pkg::COUNT_START; // R1
         state_next.running = 1'b1;
      end else if (tick) begin
         // Binary count; the top stage falls on the 256th tick.
         state_next.count = state_reg.count + 8'h01; // R4 R9
      end

      // Register writes take effect at the edge where ack is sampled.
      if (wb_write) begin
         unique case (word_idx)
            timer_pkg::IDX_CTRL: begin
               if (i_wb_sel[0]) begin
                  state_next.ext_clock = i_wb_dat[timer_pkg::CTRL_EXT_CLOCK_BIT];
                  state_next.mono = i_wb_dat[timer_pkg::CTRL_MONO_BIT];
               end
            end
            timer_pkg::IDX_SELECT: begin
               if (i_wb_sel[0]) begin
                  state_next.select = i_wb_dat[7:0];
               end
            end
            timer_pkg::IDX_PERIOD: begin
               if (i_wb_sel[0]) begin
                  state_next.period[7:0] = i_wb_dat[7:0];
               end
               if (i_wb_sel[1]) begin
                  state_next.period[15:8] = i_wb_dat[15:8];
               end
            end
            default: begin
            end
         endcase
      end

      // Wired-OR: low while any selected stage is low.
      state_next.combined = &(state_next.count | ~state_next.select); // R5 R10

      // One ack per request, dropped in the following cycle.
      state_next.ack = wb_req & ~state_reg.ack;
      if (wb_req & ~state_reg.ack) begin
         state_next.rdata = timer_pkg::READ_ZERO;
         unique case (word_idx)
            timer_pkg::IDX_CTRL: begin
               state_next.rdata[timer_pkg::CTRL_EXT_CLOCK_BIT] = state_reg.ext_clock;
               state_next.rdata[timer_pkg::CTRL_MONO_BIT] = state_reg.mono;
            end
            timer_pkg::IDX_SELECT: begin
               state_next.rdata[7:0] = state_reg.select;
            end
            timer_pkg::IDX_PERIOD: begin
               state_next.rdata[15:0] = state_reg.period;
            end
            timer_pkg::IDX_STATUS: begin
               state_next.rdata[timer_pkg::STAT_RUNNING_BIT] = state_reg.running;
               state_next.rdata[timer_pkg::STAT_COMBINED_BIT] = state_reg.combined;
               state_next.rdata[timer_pkg::STAT_COUNT_LSB +: 8] = state_reg.count;
               state_next.rdata[timer_pkg::STAT_PINS_LSB +: 8] = i_count_pin;
            end
            default: begin
            end
         endcase
      end
   end

   // State register; after reset the counter is stopped with outputs high.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_reg.count <= timer_pkg::COUNT_STOPPED;
         state_reg.running <= 1'b0;
         state_reg.combined <= 1'b1;
         state_reg.tick_out <= 1'b0;
         state_reg.trig_prev <= 1'b0;
         state_reg.ext_prev <= 1'b0;
         state_reg.select <= timer_pkg::SELECT_RESET;
         state_reg.ext_clock <= 1'b0;
         state_reg.mono <= 1'b0;
         state_reg.period <= TB_PERIOD;
         state_reg.ack <= 1'b0;
         state_reg.rdata <= timer_pkg::READ_ZERO;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // Open-collector stages pull low while their bit is low.
   assign o_count_pin = 8'h00;
   assign o_count_pin_oe_n = state_reg.count; // R4

   // Bus and observation outputs.
   assign o_wb_dat = state_reg.rdata;
   assign o_wb_ack = state_reg.ack;
   assign o_combined = state_reg.combined;
   assign o_count_msb_output = state_reg.count[7]; // R9
   assign o_count_lsb_output = state_reg.count[0];
   assign o_count_stage_five_output = state_reg.count[5];
   assign o_time_base_tick = state_reg.tick_out;
   assign o_running = state_reg.running;

endmodule : binary_delay_timer

// [tick_divider.sv]
`timescale 1ns/1ps

package timer_pkg;
   // Clock and time-base figures.
   localparam int unsigned CLOCK_PERIOD_NS = 50;
   localparam int unsigned TB_PERIOD_NS = 500000;
   localparam int unsigned TB_PERIOD_CYCLES = (TB_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   // Register word indices; the byte address is four times the index.
   localparam logic [5:0] IDX_CTRL = 6'h00;
   localparam logic [5:0] IDX_SELECT = 6'h01;
   localparam logic [5:0] IDX_PERIOD = 6'h02;
   localparam logic [5:0] IDX_STATUS = 6'h03;

   // Control register bit positions.
   localparam int unsigned CTRL_TRIGGER_BIT = 0;
   localparam int unsigned CTRL_STOP_BIT = 1;
   localparam int unsigned CTRL_EXT_CLOCK_BIT = 2;
   localparam int unsigned CTRL_MONO_BIT = 3;

   // Status register field positions.
   localparam int unsigned STAT_RUNNING_BIT = 0;
   localparam int unsigned STAT_COMBINED_BIT = 1;
   localparam int unsigned STAT_COUNT_LSB = 8;
   localparam int unsigned STAT_PINS_LSB = 16;

   // Values after reset and at a start.
   localparam logic [7:0] COUNT_STOPPED = 8'hff;
   localparam logic [7:0] COUNT_START = 8'h00;
   localparam logic [7:0] SELECT_RESET = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h00000000;
endpackage : timer_pkg

////////////////////////////////////////////////////////////////////////////////

module tick_divider (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst,
   // Control.
   input wire logic i_enable,
   input wire logic [15:0] i_period,
   // Tick out.
   output logic o_tick
);

   typedef struct packed {
      logic [15:0] count;
      logic tick;
   } div_state_t;

   div_state_t state_reg;
   div_state_t state_next;
   logic [15:0] period_eff;

   // A zero period would never tick, so it counts as one cycle.
   assign period_eff = (i_period == 16'h0000) ? 16'h0001 : i_period;

   // Down-counter that restarts a full period whenever it is held off.
   always_comb begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (!i_enable) begin
         state_next.count = period_eff - 16'h0001;
      end else if (state_reg.count == 16'h0000) begin
         state_next.count = period_eff - 16'h0001;
         state_next.tick = 1'b1;
      end else begin
         state_next.count = state_reg.count - 16'h0001;
      end
   end

   // State register.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_tick = state_reg.tick;

endmodule : tick_divider

// [timer_props.sv]
`timescale 1ns/1ps

// Checks the timer pins against the control flip-flop and counter behaviour.
module timer_props (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst,
   // Inputs watched.
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_trigger,
   input wire logic i_reset,
   // Outputs watched.
   input wire logic o_wb_ack,
   input wire logic [7:0] o_count_pin,
   input wire logic [7:0] o_count_pin_oe_n,
   input wire logic o_combined,
   input wire logic o_count_msb_output,
   input wire logic o_count_lsb_output,
   input wire logic o_count_stage_five_output,
   input wire logic o_running
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);

   // A bus request is answered one cycle later by a single-cycle ack.
   a_bus_ack_pulse: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
      else $error("bus ack is not a one cycle answer");
   // Open-collector stages only ever pull low.
   a_pins_pull_low: assert property (o_count_pin == 8'h00)
      else $error("counter pin drives high");
   a_trigger_start: assert property ($rose(i_trigger) && !o_running && !i_reset && !i_wb_cyc
      |=> o_running && o_count_pin_oe_n == 8'h00)
      else $error("trigger did not start the count from zero");
   // A wrap from all ones or a feedback stop may legally follow, so those cycles are left out.
   a_trigger_ignored: assert property ($rose(i_trigger) && o_running && !i_reset && !i_wb_cyc
      && o_count_pin_oe_n != 8'hff && !o_combined
      |=> o_running && o_count_pin_oe_n != 8'h00)
      else $error("trigger restarted a running count");
   a_reset_stops: assert property (i_reset |=> !o_running && o_count_pin_oe_n == 8'hff)
      else $error("reset did not stop the counter with outputs high");
   a_stopped_high: assert property (!o_running |-> o_count_pin_oe_n == 8'hff && o_combined)
      else $error("stopped counter shows a low output");
   a_stage_taps: assert property (o_count_msb_output == o_count_pin_oe_n[7]
      && o_count_lsb_output == o_count_pin_oe_n[0]
      && o_count_stage_five_output == o_count_pin_oe_n[5])
      else $error("stage outputs disagree with the counter");
   a_count_step: assert property (o_running && $past(o_running)
      && o_count_pin_oe_n != $past(o_count_pin_oe_n)
      |-> o_count_pin_oe_n == $past(o_count_pin_oe_n) + 8'h01)
      else $error("counter moved by other than one");
   a_msb_wrap: assert property ($fell(o_count_msb_output) |-> o_count_pin_oe_n == 8'h00)
      else $error("top stage fell away from the wrap");
endmodule : timer_props

bind binary_delay_timer timer_props props_u (.i_clock(i_clock), .i_rst(i_rst),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_trigger(i_trigger), .i_reset(i_reset),
   .o_wb_ack(o_wb_ack), .o_count_pin(o_count_pin), .o_count_pin_oe_n(o_count_pin_oe_n),
   .o_combined(o_combined), .o_count_msb_output(o_count_msb_output),
   .o_count_lsb_output(o_count_lsb_output),
   .o_count_stage_five_output(o_count_stage_five_output), .o_running(o_running));

// [timer_far_side.sv]
`timescale 1ns/1ps

// External circuit: pull-ups on the wired pins and a slow external tick.
module timer_far_side (
   // Clock.
   input wire logic i_clock,
   // Control and pins.
   input wire logic i_en,
   input wire logic [7:0] i_oe_n,
   output logic o_tick,
   output logic [7:0] o_pin,
   output logic [15:0] o_falls
);
   logic [1:0] phase;

   // A released pin is lifted by its pull-up; a driven pin reads low.
   assign o_pin = i_oe_n;

   // Tick of six cycles, held low while disabled; falling edges are counted.
   initial begin
      o_tick = 1'b0;
      phase = 2'd0;
      o_falls = 16'h0000;
   end
   always @(posedge i_clock) begin
      if (!i_en) begin
         o_tick <= 1'b0;
         phase <= 2'd0;
         o_falls <= 16'h0000;
      end else if (phase == 2'd2) begin
         phase <= 2'd0;
         o_tick <= !o_tick;
         if (o_tick) o_falls <= o_falls + 16'h0001;
      end else phase <= phase + 2'd1;
   end
endmodule : timer_far_side

// [binary_delay_timer_test.sv]
`timescale 1ns/1ps

// Self-checking bench for the delay timer.
module binary_delay_timer_test;
   localparam logic [15:0] period = 16'h0004;
   logic i_clock, i_rst, cyc, stb, we, trig, rst_pin, en, ack, comb, msb, lsb, five, tick, run, ext;
   logic [7:0] adr, pin, oe_n, pin_out;
   logic [3:0] sel;
   logic [15:0] falls;
   logic [31:0] wdat, rdat, q;
   int num_errors = 0, tests_run = 0, cycles = 0, n;

   binary_delay_timer #(.TB_PERIOD(period)) dut_u (.i_clock(i_clock), .i_rst(i_rst),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_trigger(trig), .i_reset(rst_pin),
      .i_ext_tick(ext), .i_count_pin(pin), .o_count_pin(pin_out), .o_count_pin_oe_n(oe_n),
      .o_combined(comb), .o_count_msb_output(msb), .o_count_lsb_output(lsb),
      .o_count_stage_five_output(five), .o_time_base_tick(tick), .o_running(run));
   timer_far_side far_u (.i_clock(i_clock), .i_en(en), .i_oe_n(oe_n), .o_tick(ext),
      .o_pin(pin), .o_falls(falls));

   ////////////////////////////////////////////////////////////////////////////
   // Compares one value and counts the result.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One classic Wishbone cycle; read data lands in q.
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s);
      int k;
      k = 0;
      @(posedge i_clock);
      {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, s};
      do begin
         @(posedge i_clock);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = rdat;
      {cyc, stb, we} <= 3'b000;
   endtask : wb

   // Prints the counts and the verdict.
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////////
   // Reset state, period default and an unmapped read.
   task automatic after_reset();
      wb(8'h0c, 1'b0, 32'h0, 4'hf);
      check("status", q, 32'h00ffff02);
      wb(8'h08, 1'b0, 32'h0, 4'hf);
      check("period", q, {16'h0000, period});
      wb(8'h10, 1'b0, 32'h0, 4'hf);
      check("unmapped", q, 32'h0);
      $display("reset test done");
   endtask : after_reset

   // Monostable delay with a retrigger in mid-count.
   task automatic mono_run(input logic [7:0] s, input int ticks);
      wb(8'h04, 1'b1, {24'h0, s}, 4'hf);
      wb(8'h00, 1'b1, 32'h8, 4'hf);
      @(posedge i_clock) trig <= 1'b1;
      @(posedge i_clock) trig <= 1'b0;
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
         trig <= (n == 40);
      end while (comb !== 1'b1 && n < 5000);
      check("low periods", n / period, ticks);
      repeat (2) @(posedge i_clock);
      check("mono stop", run, 1'b0);
      $display("mono test done");
   endtask : mono_run

   // Free-running count on the external tick, then reset against trigger.
   task automatic astable_ext();
      wb(8'h04, 1'b1, 32'h0, 4'hf);
      wb(8'h00, 1'b1, 32'h4, 4'hf);
      @(posedge i_clock) trig <= 1'b1;
      @(posedge i_clock) trig <= 1'b0;
      @(posedge i_clock) en <= 1'b1;
      n = 0;
      while (msb !== 1'b1 && n < 4000) begin
         @(posedge i_clock);
         n++;
      end
      while (msb !== 1'b0 && n < 4000) begin
         @(posedge i_clock);
         n++;
      end
      check("ticks at msb fall", falls, 32'd256);
      check("free run", run, 1'b1);
      @(posedge i_clock) {rst_pin, trig, en} <= 3'b110;
      repeat (2) @(posedge i_clock);
      {rst_pin, trig} <= 2'b00;
      @(posedge i_clock);
      check("reset wins", {run, oe_n}, 9'h0ff);
      $display("astable test done");
   endtask : astable_ext

   // Byte-lane period write, bus start and stop, then a reset in mid-count.
   task automatic sw_and_reset();
      wb(8'h08, 1'b1, 32'h00001208, 4'h1);
      wb(8'h08, 1'b0, 32'h0, 4'hf);
      check("period lane", q, 32'h00000008);
      wb(8'h04, 1'b1, 32'h1, 4'hf);
      wb(8'h00, 1'b1, 32'h1, 4'hf);
      repeat (40) @(posedge i_clock);
      wb(8'h0c, 1'b0, 32'h0, 4'hf);
      check("bus start", q[0], 1'b1);
      check("count moved", q[15:8] != 8'h00, 1'b1);
      wb(8'h00, 1'b1, 32'h2, 4'hf);
      wb(8'h0c, 1'b0, 32'h0, 4'hf);
      check("bus stop", q, 32'h00ffff02);
      @(posedge i_clock) trig <= 1'b1;
      @(posedge i_clock) trig <= 1'b0;
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      check("reset run", run, 1'b0);
      wb(8'h08, 1'b0, 32'h0, 4'hf);
      check("reset period", q, {16'h0000, period});
      wb(8'h0c, 1'b0, 32'h0, 4'hf);
      check("reset status", q, 32'h00ffff02);
      $display("bus and reset test done");
   endtask : sw_and_reset

   ////////////////////////////////////////////////////////////////////////////
   // Clock.
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   // Hang guard.
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         test_done();
      end
   end

   // Main sequence.
   initial begin
      {i_rst, cyc, stb, we, trig, rst_pin, en, adr, wdat} = {7'h40, 8'h00, 32'h0};
      sel = 4'h0;
      repeat (16) @(posedge i_clock);
      i_rst <= 1'b0;
      after_reset();
      mono_run(8'h20, 32);
      mono_run(8'hff, 255);
      astable_ext();
      sw_and_reset();
      test_done();
   end
endmodule : binary_delay_timer_test
